// [src/loader_defines.svh]
// Constants for the flash image configuration loader
`ifndef LOADER_DEFINES_SVH
`define LOADER_DEFINES_SVH
`define CLK_NS 50
`define FLASH_AW 26
`define FLASH_DW 16
`define CNT_W 12
`define OPT_BASE_BYTE 32'h0003_0000
`define FAC_BASE_BYTE 32'h0004_0000
`define USR_BASE_BYTE 32'h038C_0000
`define IMG_SPAN_BYTE 32'h0388_0000
`define LOC_ERASED 32'hFFFF_FFFF
`define OPT_WORDS 2'h3
`define T_ACC_NS 100
`define ACC_CYC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define T_PROG_NS 200000
`define PROG_CYC ((`T_PROG_NS + `CLK_NS - 1) / `CLK_NS)
`define BOOT_WAIT_CYC 4
`define CMD_PROGRAM 16'h0040
`define RA_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PADDR 8'h08
`define REG_PDATA 8'h0C
`define REG_ISTAT 8'h10
`define REG_IMASK 8'h14
`define CTRL_PROG_EN 0
`define EV_W 3
`define EV_DONE 0
`define EV_ERR 1
`define EV_PROG 2
`endif

// [src/loader_pkg.sv]
// Types for the flash image configuration loader
`include "loader_defines.svh"
package loader_pkg;
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_OPT_RD,
    ST_LOAD,
    ST_PARK,
    ST_PROG
  } state_t;

  typedef struct packed {
    state_t st;
    logic [`CNT_W-1:0] cnt;
    logic [`FLASH_AW-1:0] addr;
    logic [`FLASH_AW-1:0] left;
    logic [63:0] loc;
    logic [1:0] idx;
    logic sel;
    logic [2:0] sel_s;
    logic [2:0] tdone_s;
    logic [2:0] terr_s;
    logic [`FLASH_DW-1:0] data;
    logic valid;
    logic done;
    logic err;
    logic prog_en;
    logic [`FLASH_AW-1:0] paddr;
    logic [`FLASH_DW-1:0] pdata;
    logic pbusy;
    logic [`EV_W-1:0] ist;
    logic [`EV_W-1:0] imask;
    logic [31:0] rdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [`FLASH_DW-1:0] dq_out;
    logic dq_oe;
  } loader_state_t;
endpackage

// [src/flash_image_config_loader.sv]
// Flash-to-target configuration loader with host programming path
// Operation
// R1: After reset the selected image is read from flash and streamed to the target 16 bits at a time.
// R2: The image-select pin is sampled at boot, 1 picks the factory image and 0 the user image.
// R3: Reset while powered restarts the whole load sequence exactly as power-up does.
// R4: Successful configuration drives the done output, failure drives the separate error output.
// R5: The flash port addresses a 1-Gbit synchronous CFI flash with a 16-bit data bus.
// R6: The loader is the only master of the flash bus.
// R7: Locator bits sit at 0x00030000, factory image at 0x00040000, user image at 0x038C0000, each 57,856 KB.
// R8: Region boundaries are byte addresses, converted to 16-bit word addresses on the flash bus.
// R9: The locator region is read first to find the image start addresses used for loading.
// R10: Host data arriving over JTAG is written by the loader into its flash.
// R11: The host programs the flash only over JTAG with this controller in the chain.
// R12: Flash content is written only from the host, never by the target.
// R13: After a full erase the host rewrites the locator region along with the images.
// R14: Loader and host use the same fixed image map.
// R15: After an error the loader holds the error output and stops streaming until reset.
`timescale 1ns/1ps
`include "loader_defines.svh"
module flash_image_config_loader (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic image_select,
  output logic [`FLASH_AW-1:0] flash_addr,
  input wire logic [`FLASH_DW-1:0] flash_dq_in,
  output logic [`FLASH_DW-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_adv_n,
  output logic flash_clk,
  output logic [`FLASH_DW-1:0] cfg_data,
  output logic cfg_valid,
  input wire logic cfg_ready,
  input wire logic target_done,
  input wire logic target_error,
  output logic config_done,
  output logic config_error,
  input wire logic [`RA_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  loader_pkg::loader_state_t r;
  loader_pkg::loader_state_t n;
  logic rd_cap;
  logic [31:0] start_byte;
  logic [31:0] loc_pick;
  logic [63:0] loc_new;

  // Read strobe completes after the access time has elapsed
  assign rd_cap = (r.cnt == `CNT_W'(`ACC_CYC));
  // Erased locator falls back to the fixed map shared with the host [R14]
  // Last locator word is still on the bus when the start address is chosen
  assign loc_new = (r.st == loader_pkg::ST_OPT_RD) ? {flash_dq_in, r.loc[63:16]} : r.loc;
  assign loc_pick = r.sel ? loc_new[31:0] : loc_new[63:32]; // [R2]
  assign start_byte = (loc_pick != `LOC_ERASED) ? loc_pick
                    : (r.sel ? `FAC_BASE_BYTE : `USR_BASE_BYTE); // [R7] [R9]

  always_comb begin
    n = r;
    n.rdata = '0;
    n.sel_s = {r.sel_s[1:0], image_select};
    n.tdone_s = {r.tdone_s[1:0], target_done};
    n.terr_s = {r.terr_s[1:0], target_error};
    if (r.valid && cfg_ready) begin
      n.valid = 1'b0;
    end
    // Clears land before the state machine so a same-cycle event wins
    if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        n.prog_en = reg_wdata[`CTRL_PROG_EN];
      end else if (reg_addr == `REG_PADDR) begin
        n.paddr = reg_wdata[`FLASH_AW-1:0];
      end else if (reg_addr == `REG_PDATA) begin
        // Ignored while a word is still being programmed
        if (!r.pbusy && r.prog_en) begin
          n.pdata = reg_wdata[`FLASH_DW-1:0];
          n.pbusy = 1'b1; // [R10]
        end
      end else if (reg_addr == `REG_ISTAT) begin
        n.ist = r.ist & ~reg_wdata[`EV_W-1:0];
      end else if (reg_addr == `REG_IMASK) begin
        n.imask = reg_wdata[`EV_W-1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `REG_CTRL) begin
        n.rdata = {31'h0, r.prog_en};
      end else if (reg_addr == `REG_STATUS) begin
        n.rdata = {25'h0, r.st, r.pbusy, r.sel, r.err, r.done};
      end else if (reg_addr == `REG_PADDR) begin
        n.rdata = {6'h0, r.paddr};
      end else if (reg_addr == `REG_PDATA) begin
        n.rdata = {16'h0, r.pdata};
      end else if (reg_addr == `REG_ISTAT) begin
        n.rdata = {29'h0, r.ist};
      end else if (reg_addr == `REG_IMASK) begin
        n.rdata = {29'h0, r.imask};
      end
    end
    case (r.st)
      loader_pkg::ST_BOOT: begin
        // Let the select synchroniser fill before sampling
        if (r.cnt == `CNT_W'(`BOOT_WAIT_CYC)) begin
          if (r.sel_s[2] == r.sel_s[1]) begin
            n.sel = r.sel_s[2]; // [R2]
            n.st = loader_pkg::ST_OPT_RD;
            n.addr = `FLASH_AW'(`OPT_BASE_BYTE >> 1); // [R8] [R9]
            n.idx = 2'h0;
            n.cnt = '0;
          end
        end else begin
          n.cnt = r.cnt + `CNT_W'(1);
        end
      end
      loader_pkg::ST_OPT_RD, loader_pkg::ST_LOAD: begin
        // Waiting word is handed over first; a target that never takes it stalls here
        if (r.st == loader_pkg::ST_LOAD && r.cnt == '0 && r.terr_s[2] && r.terr_s[1]
            && (!r.valid || cfg_ready)) begin
          n.err = 1'b1; // [R4] [R15]
          n.valid = 1'b0;
          n.ist[`EV_ERR] = 1'b1;
          n.st = loader_pkg::ST_PARK;
        end else if (r.st == loader_pkg::ST_LOAD && r.cnt == '0 && r.tdone_s[2] && r.tdone_s[1]) begin
          n.done = 1'b1; // [R4]
          n.ist[`EV_DONE] = 1'b1;
          n.st = loader_pkg::ST_PARK;
        end else if (r.st == loader_pkg::ST_LOAD && r.cnt == '0 && r.left == '0 && !r.valid) begin
          // Image ran out without the target finishing
          n.err = 1'b1; // [R4] [R15]
          n.ist[`EV_ERR] = 1'b1;
          n.st = loader_pkg::ST_PARK;
        end else if (r.cnt == '0) begin
          // One word in flight at a time: no read until the last is taken
          if (r.st == loader_pkg::ST_OPT_RD || !r.valid) begin
            n.ce_n = 1'b0; // [R5]
            n.oe_n = 1'b0;
            n.cnt = `CNT_W'(1);
          end
        end else if (rd_cap) begin
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.cnt = '0;
          n.addr = r.addr + `FLASH_AW'(1);
          if (r.st == loader_pkg::ST_OPT_RD) begin
            n.loc = {flash_dq_in, r.loc[63:16]}; // [R9]
            n.idx = r.idx + 2'h1;
            if (r.idx == `OPT_WORDS) begin
              n.st = loader_pkg::ST_LOAD;
              n.addr = start_byte[`FLASH_AW:1]; // [R8]
              n.left = `FLASH_AW'(`IMG_SPAN_BYTE >> 1); // [R7]
            end
          end else begin
            n.data = flash_dq_in; // [R1]
            n.valid = 1'b1;
            n.left = r.left - `FLASH_AW'(1);
          end
        end else begin
          n.cnt = r.cnt + `CNT_W'(1);
        end
      end
      loader_pkg::ST_PARK: begin
        // Programming only once the load has settled, so one master owns the bus
        if (r.pbusy) begin
          n.st = loader_pkg::ST_PROG; // [R6]
          n.cnt = '0;
          n.addr = r.paddr;
        end
      end
      loader_pkg::ST_PROG: begin
        n.cnt = r.cnt + `CNT_W'(1);
        if (r.cnt == `CNT_W'(0)) begin
          n.ce_n = 1'b0;
          n.we_n = 1'b0;
          n.dq_oe = 1'b1;
          n.dq_out = `CMD_PROGRAM; // [R10]
        end else if (r.cnt == `CNT_W'(2)) begin
          n.we_n = 1'b0;
          n.dq_out = r.pdata; // [R10]
        end else if (r.cnt == `CNT_W'(1) || r.cnt == `CNT_W'(3)) begin
          n.we_n = 1'b1;
        end else if (r.cnt == `CNT_W'(4)) begin
          n.ce_n = 1'b1;
          n.dq_oe = 1'b0;
        end else if (r.cnt == `CNT_W'(`PROG_CYC)) begin
          n.pbusy = 1'b0;
          n.ist[`EV_PROG] = 1'b1;
          n.st = loader_pkg::ST_PARK;
          n.cnt = '0;
        end
      end
      default: begin
        n.st = loader_pkg::ST_BOOT;
      end
    endcase
  end

  // Any reset, power-up or pushbutton, reruns the full sequence [R3]
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.st <= loader_pkg::ST_BOOT;
      r.ce_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign flash_addr = r.addr;
  assign flash_dq_out = r.dq_out;
  assign flash_dq_oe = r.dq_oe;
  assign flash_ce_n = r.ce_n;
  assign flash_oe_n = r.oe_n;
  assign flash_we_n = r.we_n;
  // Asynchronous access mode: address latch open, burst clock idle
  assign flash_adv_n = 1'b0;
  assign flash_clk = 1'b0;
  assign cfg_data = r.data;
  assign cfg_valid = r.valid;
  assign config_done = r.done;
  assign config_error = r.err;
  assign reg_rdata = r.rdata;
  assign irq = |(r.ist & r.imask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_opt_last;
    r.st == loader_pkg::ST_OPT_RD ##1 r.st == loader_pkg::ST_LOAD;
  endsequence

  property p_outcome_excl;
    !(config_done && config_error);
  endproperty
  a_outcome_excl: assert property (p_outcome_excl) else $error("done and error both set"); // [R4]

  property p_err_hold;
    config_error |=> config_error && !cfg_valid;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped or streaming resumed"); // [R15]

  property p_stream_hold;
    cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data);
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream word lost before taken"); // [R1]

  property p_read_width;
    $fell(flash_oe_n) |-> !flash_oe_n[*2] ##1 flash_oe_n;
  endproperty
  a_read_width: assert property (p_read_width) else $error("flash read strobe wrong length"); // [R5]

  property p_sole_master;
    flash_dq_oe |-> flash_oe_n && !flash_ce_n;
  endproperty
  a_sole_master: assert property (p_sole_master) else $error("data bus driven during flash read"); // [R6]

  property p_opt_region;
    r.st == loader_pkg::ST_OPT_RD |-> flash_addr[`FLASH_AW-1:2] == `FLASH_AW'(`OPT_BASE_BYTE >> 1) >> 2;
  endproperty
  a_opt_region: assert property (p_opt_region) else $error("locator read outside its region"); // [R9]

  property p_start_word;
    s_opt_last |-> flash_addr == start_byte[`FLASH_AW:1];
  endproperty
  a_start_word: assert property (p_start_word) else $error("image start not a word address"); // [R8]

  property p_prog_cmd;
    $rose(flash_dq_oe) |-> flash_dq_out == `CMD_PROGRAM && !flash_we_n ##1 flash_we_n ##1
      (!flash_we_n && flash_dq_out == r.pdata);
  endproperty
  a_prog_cmd: assert property (p_prog_cmd) else $error("program sequence malformed"); // [R10]

  property p_sel_kept;
    s_opt_last |-> r.sel == $past(r.sel, 2);
  endproperty
  a_sel_kept: assert property (p_sel_kept) else $error("image choice changed during load"); // [R2]

  property p_no_stray_write;
    r.st != loader_pkg::ST_PROG |-> flash_we_n && !flash_dq_oe;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("flash written outside programming"); // [R6]

  property p_stream_from_read;
    $rose(cfg_valid) |-> !$past(flash_oe_n);
  endproperty
  a_stream_from_read: assert property (p_stream_from_read) else $error("stream word without flash read"); // [R1]

  property p_prog_after_load;
    $rose(flash_dq_oe) |-> config_done || config_error;
  endproperty
  a_prog_after_load: assert property (p_prog_after_load) else $error("programming before load ended"); // [R6]

  property p_done_event;
    $rose(config_done) |-> r.ist[`EV_DONE];
  endproperty
  a_done_event: assert property (p_done_event) else $error("done without status event"); // [R4]
endmodule // flash_image_config_loader

// [verification/loader_far_side.sv]
// Flash array and target configuration port seen by the loader
`timescale 1ns/1ps
`include "loader_defines.svh"
module loader_far_side (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`FLASH_AW-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  output logic [`FLASH_DW-1:0] flash_dq_in,
  input wire logic cfg_valid,
  output logic cfg_ready,
  input wire logic stall,
  input wire logic fail,
  input wire logic [15:0] limit,
  output logic target_done,
  output logic target_error
);
  logic [15:0] word;
  logic [15:0] last_word;
  logic [15:0] taken;
  always_comb begin
    case (flash_addr)
      26'h0018000, 26'h0018001: word = 16'hFFFF; // Factory locator erased
      26'h0018002: word = 16'h0000;
      26'h0018003: word = 16'h038C;
      default: word = flash_addr[15:0] ^ 16'h5A5A;
    endcase
  end
  // Released bus shows the inverse so a late capture is caught
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? word : ~last_word;
  always @(posedge mclk) begin
    if (!flash_ce_n && !flash_oe_n) begin
      last_word <= word;
    end
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      taken <= 16'h0000;
      cfg_ready <= 1'b0;
      target_done <= 1'b0;
      target_error <= 1'b0;
    end else begin
      cfg_ready <= !stall;
      if (cfg_valid && cfg_ready) begin
        taken <= taken + 16'h0001;
      end
      if (taken == limit) begin
        target_done <= !fail;
        target_error <= fail;
      end
    end
  end
endmodule // loader_far_side

// [verification/flash_image_config_loader_bench.sv]
// Self-checking bench for the flash image configuration loader
`timescale 1ns/1ps
`include "loader_defines.svh"
module flash_image_config_loader_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic image_select = 1'b1;
  logic [`FLASH_AW-1:0] flash_addr;
  logic [`FLASH_DW-1:0] flash_dq_in, flash_dq_out, cfg_data;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_adv_n, flash_clk;
  logic cfg_valid, cfg_ready, target_done, target_error, config_done, config_error, irq;
  logic [`RA_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, stall = 1'b0, fail = 1'b0, quiet;
  logic [15:0] limit = 16'h0010;
  logic [31:0] seed, pd;
  logic [25:0] pa;
  logic [15:0] sq[$];
  logic [63:0] rq[$];
  logic [41:0] wq[$];
  int errors = 0, tests_run = 0, i;
  always #25 mclk = ~mclk;
  flash_image_config_loader dut (.mclk(mclk), .resetn(resetn), .image_select(image_select),
    .flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_adv_n(flash_adv_n),
    .flash_clk(flash_clk), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
    .target_done(target_done), .target_error(target_error), .config_done(config_done),
    .config_error(config_error), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  loader_far_side far (.mclk(mclk), .resetn(resetn), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
    .stall(stall), .fail(fail), .limit(limit), .target_done(target_done), .target_error(target_error));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic bound(input logic ok, input string msg);
    chk(ok, msg);
    if (ok !== 1'b1) end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back({mask, exp});
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // Restart with a chosen image; the stream must begin at its first word
  task automatic load(input logic sel, input logic f, input logic [15:0] lim, input logic [25:0] base);
    @(posedge mclk);
    resetn <= 1'b0;
    image_select <= sel;
    fail <= f;
    limit <= lim;
    // A word taken at the reset edge still belongs to the old run
    @(posedge mclk);
    sq.delete();
    for (int k = 0; k < lim + 6; k++) sq.push_back(base[15:0] + k[15:0] ^ 16'h5A5A);
    repeat (19) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 100 && flash_ce_n !== 1'b0; i++) @(posedge mclk);
    bound(flash_ce_n === 1'b0, "no flash read after reset");
    chk(flash_addr === 26'h0018000, "locator word address");
  endtask
  always @(posedge mclk) begin
    stall <= ($random(seed) % 4) == 0;
    rd_q <= reg_rd;
    if (rd_q && rq.size() > 0) begin
      chk((reg_rdata & rq[0][63:32]) === rq[0][31:0], "register read value");
      void'(rq.pop_front());
    end
    if (resetn && cfg_valid && cfg_ready) begin
      if (sq.size() == 0) chk(1'b0, "unexpected stream word");
      else chk(cfg_data === sq.pop_front(), "stream word order");
    end
  end
  always @(posedge flash_we_n) begin
    if (resetn) chk({flash_addr, flash_dq_out} === wq.pop_front(), "flash write cycle");
  end
  initial begin
    seed = 32'h21C1;
    load(1'b0, 1'b0, 16'h0400, 26'h1C60000);
    repeat (200) @(posedge mclk);
    load(1'b1, 1'b0, 16'h0028, 26'h0020000); // Mid-run restart
    repeat (40) @(posedge mclk);
    image_select <= 1'b0;
    for (i = 0; i < 3000 && config_done !== 1'b1; i++) @(posedge mclk);
    bound(config_done === 1'b1, "no done");
    chk(config_error === 1'b0, "error with done");
    rd(`REG_STATUS, 32'h7, 32'h5);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    rd(`REG_ISTAT, 32'h7, 32'h1);
    chk(irq === 1'b0, "irq while masked");
    wr(`REG_IMASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq === 1'b1, "irq not raised");
    wr(`REG_ISTAT, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq === 1'b0, "irq not cleared");
    pa = $random(seed);
    pd = $random(seed);
    wq.push_back({pa, `CMD_PROGRAM});
    wq.push_back({pa, pd[15:0]});
    wr(`REG_PADDR, {6'h00, pa});
    wr(`REG_CTRL, 32'h1);
    wr(`REG_IMASK, 32'h4);
    wr(`REG_PDATA, pd);
    for (i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge mclk);
    bound(irq === 1'b1, "no program interrupt");
    chk(i > 3990, "program time too short");
    chk(wq.size() == 0, "flash write count");
    load(1'b0, 1'b1, 16'h0019, 26'h1C60000);
    for (i = 0; i < 3000 && config_error !== 1'b1; i++) @(posedge mclk);
    bound(config_error === 1'b1, "no error");
    quiet = 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge mclk);
      if (cfg_valid !== 1'b0 || config_error !== 1'b1) quiet = 1'b0;
    end
    chk(quiet, "stream after error");
    chk(config_done === 1'b0, "done with error");
    rd(`REG_STATUS, 32'h3, 32'h2);
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule // flash_image_config_loader_bench
